// file: bench/iod_dev_model.sv
// Behavioural device controller on the far side of the device link.
// Assumes the dispatch block's request and answer handshake on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module iod_dev_model #(
  parameter logic [7:0] ABSENT = 8'hEE,
  parameter logic [7:0] FAULTY = 8'h0B,
  parameter int DELAY = 2
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic dev_req,
  input wire logic [2:0] dev_fn,
  input wire logic [7:0] dev_addr,
  input wire logic raise,
  input wire logic [7:0] irq_id,
  output logic [7:0] dev_din,
  output logic [7:0] dev_status,
  output logic dev_resp,
  output logic dev_irq
);
  logic [3:0] wait_cnt;
  logic [7:0] seq;
  // A released link shows a pattern that changes every cycle.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wait_cnt <= 4'h0;
      seq <= 8'h30;
      dev_din <= 8'h00;
      dev_status <= 8'h00;
      dev_resp <= 1'b0;
      dev_irq <= 1'b0;
    end else begin
      if (!dev_req) begin
        dev_resp <= 1'b0;
        wait_cnt <= 4'h0;
        dev_din <= ~dev_din;
        dev_status <= ~dev_status;
      end else if (!dev_resp && dev_addr != ABSENT) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt == 4'(DELAY)) begin
          dev_resp <= 1'b1;
          dev_status <= (dev_addr == FAULTY) ? 8'h80 : 8'h00;
          dev_din <= (dev_fn == 3'h4) ? irq_id : seq;
          if (dev_fn == 3'h2) seq <= seq + 8'h01;
          if (dev_fn == 3'h0) seq <= 8'h30;
          if (dev_fn == 3'h4) dev_irq <= 1'b0;
        end
      end
      if (raise) dev_irq <= 1'b1;
    end
  end
endmodule : iod_dev_model
`default_nettype wire

// file: bench/test_io_interrupt_dispatch.sv
// Self-checking bench for the dispatch block with memory and one device.
// Assumes the design files under verilog/ are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_io_interrupt_dispatch;
  logic sys_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, cpu_boundary = 1;
  logic [7:0] reg_addr = 0, dev_addr, dev_dout, dev_din, dev_status;
  logic [7:0] irq_id = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, d;
  logic cpu_hold, ext_int, imm_int, term_int, ovf_int, raise = 0;
  logic mem_req, mem_we, mem_ack = 0, dev_req, dev_resp, dev_irq;
  logic [15:0] mem_addr, mem_wdata, mem_rdata = 0;
  logic [2:0] dev_fn;
  logic [15:0] mem [0:4095];
  int err_total = 0, check_count = 0, cyc = 0, evt = 0, ovf_n = 0;
  int term_n = 0, ext_n = 0, req_n = 0, imm_n = 0, i;
  logic [7:0] last_dev = 0, last_dout = 0;
  always #50 sys_clk = ~sys_clk;
  iod_dispatch #(.TIMEOUT_CYC(8)) DUT (.sys_clk(sys_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_boundary(cpu_boundary),
    .cpu_hold(cpu_hold), .ext_int(ext_int), .imm_int(imm_int),
    .term_int(term_int), .ovf_int(ovf_int), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .dev_req(dev_req),
    .dev_fn(dev_fn), .dev_addr(dev_addr), .dev_dout(dev_dout),
    .dev_din(dev_din), .dev_status(dev_status), .dev_resp(dev_resp),
    .dev_irq(dev_irq));
  iod_dev_model dev (.sys_clk(sys_clk), .rstn(rstn), .dev_req(dev_req),
    .dev_fn(dev_fn), .dev_addr(dev_addr), .raise(raise), .irq_id(irq_id),
    .dev_din(dev_din), .dev_status(dev_status), .dev_resp(dev_resp),
    .dev_irq(dev_irq));
  // Memory answers one cycle after each request; event pulses are counted.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    mem_ack <= mem_req && !mem_ack;
    if (mem_req && !mem_ack) mem_rdata <= mem[mem_addr[11:0]];
    if (mem_req && !mem_ack && mem_we) mem[mem_addr[11:0]] <= mem_wdata;
    evt <= evt + int'(ext_int) + int'(imm_int) + int'(term_int)
      + int'(ovf_int);
    ext_n <= ext_n + int'(ext_int);
    term_n <= term_n + int'(term_int);
    ovf_n <= ovf_n + int'(ovf_int);
    imm_n <= imm_n + int'(imm_int);
    if (dev_req && last_dev !== dev_addr) last_dev <= dev_addr;
    if (dev_req) req_n <= req_n + 1;
    if (dev_req) last_dout <= dev_dout;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1 v = reg_rdata;
  endtask : rd
  // Issues a command and polls status until the block is idle again.
  task automatic cmd(input logic [31:0] c);
    wr(8'h04, c);
    d = 32'h10;
    for (int k = 0; k < 100 && d[4] !== 1'b0; k++) rd(8'h10, d);
    chk("idle", 32'h0, {31'h0, d[4]});
  endtask : cmd
  task automatic irq(input logic [7:0] id);
    int p;
    p = evt;
    @(posedge sys_clk);
    irq_id <= id;
    raise <= 1;
    @(posedge sys_clk);
    raise <= 0;
    for (int k = 0; k < 500 && evt == p; k++) @(posedge sys_clk);
    for (int k = 0; k < 100 && cpu_hold !== 1'b0; k++) @(posedge sys_clk);
  endtask : irq
  task automatic close_out();
    $display("Checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  initial begin
    for (i = 0; i < 4096; i++) mem[i] = 16'h0000;
    repeat (5) @(posedge sys_clk);
    rstn <= 1;
    rd(8'h10, d);
    chk("stat_reset", 32'h0000_0000, d);
    rd(8'h20, d);
    chk("unmapped", 32'h0000_0000, d);
    cmd(32'h0005_00A5);
    chk("out_addr", 32'h05, {24'h0, last_dev});
    chk("out_data", 32'hA5, {24'h0, last_dout});
    wr(8'h08, 32'h0000_0500);
    wr(8'h0C, 32'h0000_0502);
    cmd(32'h0505_0000);
    for (i = 0; i < 3; i++)
      chk("blk_mem", 32'h30 + i, {24'h0, mem[12'h500 + i][7:0]});
    chk("blk_end", 32'h0, {16'h0, mem[12'h503]});
    wr(8'h08, 32'h0000_0502);
    cmd(32'h0605_0000);
    chk("blk_wr", 32'h32, {24'h0, last_dout});
    wr(8'h08, 32'h0000_0510);
    wr(8'h0C, 32'h0000_0512);
    cmd(32'h050B_0000);
    chk("blk_stop", 32'h8004, {16'h0, d[23:16], d[7:0]});
    chk("blk_none", 32'h0, {16'h0, mem[12'h510]});
    cmd(32'h01EE_0000);
    chk("timeout_cc", 32'h1, {31'h0, d[0]});
    mem[12'h046] = 16'h0123;
    irq(8'h07);
    chk("pending", 32'h0, ext_n);
    cpu_boundary <= 0;
    wr(8'h00, 32'h4000_0050);
    repeat (20) @(posedge sys_clk);
    chk("boundary", 32'h0, ext_n);
    cpu_boundary <= 1;
    for (i = 0; i < 200 && ext_n == 0; i++) @(posedge sys_clk);
    chk("ext_old_hi", 32'h4000, {16'h0, mem[12'h040]});
    chk("ext_old_lo", 32'h0050, {16'h0, mem[12'h042]});
    rd(8'h00, d);
    chk("ext_new", 32'h0000_0123, d);
    cmd(32'h0400_0000);
    chk("ack_id", 32'h0707, {16'h0, d[31:24], d[15:8]});
    mem[12'h0D6] = 16'h0200;
    mem[12'h204] = 16'h4800;
    wr(8'h00, 32'h4800_0010);
    irq(8'h03);
    chk("imm_old", 32'h4800_0010, {mem[12'h200], mem[12'h202]});
    rd(8'h00, d);
    chk("imm_new", 32'h4800_0206, d);
    chk("imm_n", 32'h1, imm_n);
    mem[12'h0D8] = 16'h0301;
    mem[12'h300] = 16'h0200;
    mem[12'h080] = 16'h0400;
    mem[12'h400] = 16'h0200;
    wr(8'h00, 32'h4A00_0000);
    irq(8'h04);
    chk("q_slot0", 32'h0300, {16'h0, mem[12'h404]});
    chk("q_hdr1", 32'h0201_0001, {mem[12'h400], mem[12'h402]});
    chk("term_n", 32'h1, term_n);
    rd(8'h00, d);
    chk("no_exch", 32'h4A00_0000, d);
    irq(8'h04);
    chk("q_slot1", 32'h0300, {16'h0, mem[12'h406]});
    chk("q_wrap", 32'h0202_0000, {mem[12'h400], mem[12'h402]});
    irq(8'h04);
    chk("ovf_ptr", 32'h0300, {16'h0, mem[12'h08A]});
    chk("ovf_n", 32'h1, ovf_n);
    wr(8'h00, 32'h0100_0000);
    i = req_n;
    cmd(32'h0105_0000);
    chk("priv_cc", 32'h2, {28'h0, d[3:0]});
    chk("priv_bus", 32'h0, req_n - i);
    close_out();
  end
endmodule : test_io_interrupt_dispatch
`default_nettype wire

// file: verilog/iod_consts.svh
// Constants for the I/O interrupt dispatch block: fixed memory locations,
// status-word bit positions, register offsets, codes and timing.
// Assumes a 16-bit halfword memory port and a 32-bit register port.
`ifndef IOD_CONSTS_SVH
`define IOD_CONSTS_SVH

// Fixed memory locations (halfword addresses).
`define IOD_LOC_EXT_OLD 16'h0040
`define IOD_LOC_EXT_NEW 16'h0044
`define IOD_LOC_QPTR 16'h0080
`define IOD_LOC_QOVF 16'h008A
`define IOD_LOC_SPT 16'h00D0

// Status-word bits (status word is psw[31:16], its bit 0 is psw[31]).
`define IOD_PSW_EXT_BIT 30
`define IOD_PSW_IMM_BIT 27
`define IOD_PSW_TERM_BIT 25
`define IOD_PSW_PROT_BIT 24
// Table entry bit 15 and function word queue bit 6 (bit 0 is the MSB).
`define IOD_SPT_ISB_BIT 0
`define IOD_FW_QUEUE_BIT 9

// Register byte offsets.
`define IOD_REG_PSW 8'h00
`define IOD_REG_CMD 8'h04
`define IOD_REG_BSTART 8'h08
`define IOD_REG_BEND 8'h0C
`define IOD_REG_STAT 8'h10

// Command codes in CMD[26:24]; codes 0 to 4 also go out on dev_fn.
`define IOD_OP_OUTCMD 3'h0
`define IOD_OP_SENSE 3'h1
`define IOD_OP_READ 3'h2
`define IOD_OP_WRITE 3'h3
`define IOD_OP_ACK 3'h4
`define IOD_OP_BLKRD 3'h5
`define IOD_OP_BLKWR 3'h6

// Condition bits in STAT[3:0].
`define IOD_CC_TMO 0
`define IOD_CC_PRIV 1
`define IOD_CC_DSTAT 2

// Device answer time-out.
`define IOD_CLK_NS 100
`define IOD_TIMEOUT_NS 10000
`define IOD_TIMEOUT_CYC (`IOD_TIMEOUT_NS / `IOD_CLK_NS)

`endif

// file: verilog/iod_dispatch.sv
// I/O dispatch: program I/O, interrupt paths, block moves, automatic I/O.
// Assumes a same-clock halfword memory that acknowledges each request and
// device controllers whose lines arrive asynchronously.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`include "iod_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RULE1] Route all transfers to one of 256 devices.
// [RULE2] Unanswered I/O times out into condition code.
// [RULE3] I/O commands refused unless in supervisor mode.
// [RULE4] External path when bit 1 set, 4 clear.
// [RULE5] Immediate path when bits 1 and 4 set.
// [RULE6] Software's external new status keeps bit 1 clear.
// [RULE7] Acknowledge command returns interrupting device address.
// [RULE8] External interrupt saves status word at old location.
// [RULE9] Immediate: acknowledge, store status, load next status.
// [RULE10] Block move stops at end or bad status.
// [RULE11] Block move takes no interrupts until done.
// [RULE12] Automatic service delays program, no status exchange.
// [RULE13] Automatic service raises interrupts on overflow or request.
// [RULE14] Automatic service only with bits 1 and 4.
// [RULE15] Read one table halfword per device address.
// [RULE16] Entry bit 15 clear: immediate exchange area.
// [RULE17] Entry bit 15 set: entry minus one.
// [RULE18] Termination queue circular, at most 255 entries.
// [RULE19] Software sets queue pointer before service blocks.
// [RULE20] Each finished service block adds a queue entry; here only when function word bit 6 is set.
// [RULE21] Table entry address is base plus twice device.
// [RULE22] Requests wait while bit 1 is clear.
// [RULE23] Full queue: store at overflow location, interrupt.
// [RULE24] Serve pending requests one by one first.
module iod_dispatch #(
  parameter int TIMEOUT_CYC = `IOD_TIMEOUT_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic cpu_boundary,
  output logic cpu_hold,
  output logic ext_int,
  output logic imm_int,
  output logic term_int,
  output logic ovf_int,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic dev_req,
  output logic [2:0] dev_fn,
  output logic [7:0] dev_addr,
  output logic [7:0] dev_dout,
  input wire logic [7:0] dev_din,
  input wire logic [7:0] dev_status,
  input wire logic dev_resp,
  input wire logic dev_irq
);

  // ==========================================================================
  // Input synchronisers.
  // ==========================================================================
  logic [17:0] sync1_reg;
  logic [17:0] sync2_reg;
  wire logic irq_s = sync2_reg[17];
  wire logic resp_s = sync2_reg[16];
  wire logic [7:0] din_s = sync2_reg[15:8];
  wire logic [7:0] dstat_s = sync2_reg[7:0];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {dev_irq, dev_resp, dev_din, dev_status};
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================================
  // State and registers.
  // ==========================================================================
  iod_pkg::iod_state_e state_reg;
  iod_pkg::iod_state_e ret_reg;
  logic [31:0] psw_reg;
  logic [31:0] cmd_reg;
  logic cmd_pend_reg;
  logic [15:0] bstart_reg;
  logic [15:0] bend_reg;
  logic [15:0] bcur_reg;
  logic [3:0] cc_reg;
  logic [7:0] result_reg;
  logic [7:0] dstat_reg;
  logic [7:0] dev_id_reg;
  logic auto_reg;
  logic blk_reg;
  logic [15:0] mem_rd_reg;
  logic [15:0] sp_reg;
  logic [15:0] qbase_reg;
  logic [7:0] qsize_reg;
  logic [7:0] qused_reg;
  logic [7:0] qnext_reg;
  logic [15:0] tmo_cnt_reg;
  logic [15:0] mem_addr_reg;
  logic mem_we_reg;
  logic [15:0] mem_wdata_reg;
  logic [2:0] dev_fn_reg;
  logic [7:0] dev_addr_reg;
  logic [7:0] dev_dout_reg;
  logic [3:0] pulse_reg;

  // ==========================================================================
  // Decodes.
  // ==========================================================================
  wire logic idle = (state_reg == iod_pkg::S_IDLE);
  wire logic ext_en = psw_reg[`IOD_PSW_EXT_BIT];
  wire logic imm_en = psw_reg[`IOD_PSW_IMM_BIT];
  wire logic psw_prot = psw_reg[`IOD_PSW_PROT_BIT];
  wire logic irq_go = cpu_boundary && irq_s && ext_en; // RULE22
  wire logic [2:0] cmd_op = cmd_reg[26:24];
  wire logic cmd_blk = (cmd_op == `IOD_OP_BLKRD) || (cmd_op == `IOD_OP_BLKWR);
  wire logic blk_wr = (cmd_op == `IOD_OP_BLKWR);
  wire logic io_wait = (state_reg == iod_pkg::S_IO)
                    || (state_reg == iod_pkg::S_ACK);
  wire logic tmo = (tmo_cnt_reg == 16'(TIMEOUT_CYC - 1));
  wire logic [15:0] spt_addr = `IOD_LOC_SPT + {7'h00, din_s, 1'b0}; // RULE21
  wire logic q_full = (qused_reg >= qsize_reg); // RULE18
  wire logic [7:0] qnext_inc = qnext_reg + 8'h01;
  wire logic [7:0] qnext_wrap = (qnext_inc >= qsize_reg) ? 8'h00 : qnext_inc;
  wire logic sel_psw = (reg_addr == `IOD_REG_PSW);
  wire logic sel_cmd = (reg_addr == `IOD_REG_CMD);
  wire logic sel_bst = (reg_addr == `IOD_REG_BSTART);
  wire logic sel_bend = (reg_addr == `IOD_REG_BEND);
  wire logic sel_stat = (reg_addr == `IOD_REG_STAT);
  wire logic [31:0] stat_word = {dev_id_reg, dstat_reg, result_reg,
                                 3'h0, !idle || cmd_pend_reg, cc_reg};
  wire logic [31:0] rd_mux = sel_psw ? psw_reg
                          : sel_cmd ? cmd_reg
                          : sel_bst ? {16'h0000, bstart_reg}
                          : sel_bend ? {16'h0000, bend_reg}
                          : sel_stat ? stat_word : 32'h0000_0000;

  assign mem_req = (state_reg == iod_pkg::S_MEM);
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign dev_req = io_wait; // RULE1
  assign dev_fn = dev_fn_reg;
  assign dev_addr = dev_addr_reg;
  assign dev_dout = dev_dout_reg;
  assign cpu_hold = !idle; // RULE12
  assign {ovf_int, term_int, imm_int, ext_int} = pulse_reg;

  // ==========================================================================
  // Register port.
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
      cmd_reg <= 32'h0000_0000;
      bstart_reg <= 16'h0000;
      bend_reg <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      if (reg_wr && sel_cmd && idle && !cmd_pend_reg) begin
        cmd_reg <= reg_wdata;
      end
      if (reg_wr && sel_bst && idle) begin
        bstart_reg <= reg_wdata[15:0];
      end
      if (reg_wr && sel_bend && idle) begin
        bend_reg <= reg_wdata[15:0];
      end
    end
  end

  // ==========================================================================
  // Dispatch sequencer.
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= iod_pkg::S_IDLE;
      ret_reg <= iod_pkg::S_IDLE;
      psw_reg <= 32'h0000_0000;
      cmd_pend_reg <= 1'b0;
      bcur_reg <= 16'h0000;
      cc_reg <= 4'h0;
      result_reg <= 8'h00;
      dstat_reg <= 8'h00;
      dev_id_reg <= 8'h00;
      auto_reg <= 1'b0;
      blk_reg <= 1'b0;
      mem_rd_reg <= 16'h0000;
      sp_reg <= 16'h0000;
      qbase_reg <= 16'h0000;
      qsize_reg <= 8'h00;
      qused_reg <= 8'h00;
      qnext_reg <= 8'h00;
      tmo_cnt_reg <= 16'h0000;
      mem_addr_reg <= 16'h0000;
      mem_we_reg <= 1'b0;
      mem_wdata_reg <= 16'h0000;
      dev_fn_reg <= 3'h0;
      dev_addr_reg <= 8'h00;
      dev_dout_reg <= 8'h00;
      pulse_reg <= 4'h0;
    end else begin
      pulse_reg <= 4'h0;
      tmo_cnt_reg <= io_wait ? tmo_cnt_reg + 16'h0001 : 16'h0000;
      if (reg_wr && sel_cmd && idle && !cmd_pend_reg) begin
        cmd_pend_reg <= 1'b1;
      end
      case (state_reg)
        iod_pkg::S_IDLE: begin
          if (reg_wr && sel_psw) begin
            psw_reg <= reg_wdata;
          end
          if (cmd_pend_reg) begin
            cmd_pend_reg <= 1'b0;
            cc_reg <= 4'h0;
            dev_fn_reg <= cmd_op;
            dev_addr_reg <= cmd_reg[23:16]; // RULE1
            dev_dout_reg <= cmd_reg[7:0];
            auto_reg <= 1'b0;
            if (psw_prot) begin
              cc_reg[`IOD_CC_PRIV] <= 1'b1; // RULE3
            end else if (cmd_blk) begin
              blk_reg <= 1'b1; // RULE11
              bcur_reg <= bstart_reg;
              dev_fn_reg <= blk_wr ? `IOD_OP_WRITE : `IOD_OP_READ;
              state_reg <= iod_pkg::S_BLK;
            end else if (cmd_op == `IOD_OP_ACK) begin
              state_reg <= iod_pkg::S_ACK;
            end else begin
              state_reg <= iod_pkg::S_IO;
            end
          end else if (irq_go && imm_en) begin
            auto_reg <= 1'b1; // RULE14
            dev_fn_reg <= `IOD_OP_ACK; // RULE9
            state_reg <= iod_pkg::S_ACK; // RULE5
          end else if (irq_go) begin
            mem_addr_reg <= `IOD_LOC_EXT_OLD; // RULE8
            mem_we_reg <= 1'b1;
            mem_wdata_reg <= psw_reg[31:16];
            ret_reg <= iod_pkg::S_E1;
            state_reg <= iod_pkg::S_MEM; // RULE4
          end
        end
        iod_pkg::S_MEM: begin
          if (mem_ack) begin
            mem_rd_reg <= mem_rdata;
            state_reg <= ret_reg;
          end
        end
        iod_pkg::S_IO, iod_pkg::S_ACK: begin
          if (resp_s) begin
            result_reg <= din_s;
            dstat_reg <= dstat_s;
            if (state_reg == iod_pkg::S_ACK) begin
              dev_id_reg <= din_s; // RULE7
            end
            if (dstat_s != 8'h00) begin
              cc_reg[`IOD_CC_DSTAT] <= 1'b1;
            end
          end else if (tmo) begin
            cc_reg[`IOD_CC_TMO] <= 1'b1; // RULE2
          end
          if (resp_s || tmo) begin
            if (blk_reg) begin
              state_reg <= iod_pkg::S_B1;
            end else if (auto_reg && resp_s) begin
              mem_addr_reg <= spt_addr; // RULE15
              mem_we_reg <= 1'b0;
              ret_reg <= iod_pkg::S_TBL;
              state_reg <= iod_pkg::S_MEM;
            end else begin
              state_reg <= iod_pkg::S_IDLE;
            end
          end
        end
        iod_pkg::S_TBL: begin
          if (mem_rd_reg[`IOD_SPT_ISB_BIT]) begin
            sp_reg <= mem_rd_reg - 16'h0001; // RULE17
            mem_addr_reg <= mem_rd_reg - 16'h0001;
            mem_we_reg <= 1'b0;
            ret_reg <= iod_pkg::S_F1;
          end else begin
            sp_reg <= mem_rd_reg; // RULE16
            mem_addr_reg <= mem_rd_reg;
            mem_we_reg <= 1'b1;
            mem_wdata_reg <= psw_reg[31:16];
            ret_reg <= iod_pkg::S_I1;
          end
          state_reg <= iod_pkg::S_MEM;
        end
        iod_pkg::S_I1: begin
          mem_addr_reg <= sp_reg + 16'h0002;
          mem_wdata_reg <= psw_reg[15:0];
          ret_reg <= iod_pkg::S_I2;
          state_reg <= iod_pkg::S_MEM;
        end
        iod_pkg::S_I2: begin
          mem_addr_reg <= sp_reg + 16'h0004;
          mem_we_reg <= 1'b0;
          ret_reg <= iod_pkg::S_I3;
          state_reg <= iod_pkg::S_MEM;
        end
        iod_pkg::S_I3: begin
          psw_reg <= {mem_rd_reg, sp_reg + 16'h0006}; // RULE9
          pulse_reg[1] <= 1'b1;
          state_reg <= iod_pkg::S_IDLE; // RULE24
        end
        iod_pkg::S_F1: begin
          if (mem_rd_reg[`IOD_FW_QUEUE_BIT]) begin
            mem_addr_reg <= `IOD_LOC_QPTR; // RULE20
            ret_reg <= iod_pkg::S_Q1;
            state_reg <= iod_pkg::S_MEM;
          end else begin
            state_reg <= iod_pkg::S_IDLE;
          end
        end
        iod_pkg::S_Q1: begin
          qbase_reg <= mem_rd_reg;
          mem_addr_reg <= mem_rd_reg;
          ret_reg <= iod_pkg::S_Q2;
          state_reg <= iod_pkg::S_MEM;
        end
        iod_pkg::S_Q2: begin
          qsize_reg <= mem_rd_reg[15:8];
          qused_reg <= mem_rd_reg[7:0];
          mem_addr_reg <= qbase_reg + 16'h0002;
          ret_reg <= iod_pkg::S_Q3;
          state_reg <= iod_pkg::S_MEM;
        end
        iod_pkg::S_Q3: begin
          mem_we_reg <= 1'b1;
          mem_wdata_reg <= sp_reg;
          state_reg <= iod_pkg::S_MEM;
          if (q_full) begin
            mem_addr_reg <= `IOD_LOC_QOVF; // RULE23
            ret_reg <= iod_pkg::S_OVF;
          end else begin
            qnext_reg <= mem_rd_reg[7:0];
            mem_addr_reg <= qbase_reg + 16'h0004
                            + {7'h00, mem_rd_reg[7:0], 1'b0};
            ret_reg <= iod_pkg::S_Q4;
          end
        end
        iod_pkg::S_Q4: begin
          mem_addr_reg <= qbase_reg + 16'h0002;
          mem_wdata_reg <= {8'h00, qnext_wrap}; // RULE18
          ret_reg <= iod_pkg::S_Q5;
          state_reg <= iod_pkg::S_MEM;
        end
        iod_pkg::S_Q5: begin
          mem_addr_reg <= qbase_reg;
          mem_wdata_reg <= {qsize_reg, qused_reg + 8'h01};
          ret_reg <= iod_pkg::S_Q6;
          state_reg <= iod_pkg::S_MEM;
        end
        iod_pkg::S_Q6: begin
          pulse_reg[2] <= psw_reg[`IOD_PSW_TERM_BIT]; // RULE13
          state_reg <= iod_pkg::S_IDLE;
        end
        iod_pkg::S_OVF: begin
          pulse_reg[3] <= 1'b1; // RULE13
          state_reg <= iod_pkg::S_IDLE;
        end
        iod_pkg::S_E1: begin
          mem_addr_reg <= `IOD_LOC_EXT_OLD + 16'h0002;
          mem_wdata_reg <= psw_reg[15:0];
          ret_reg <= iod_pkg::S_E2;
          state_reg <= iod_pkg::S_MEM;
        end
        iod_pkg::S_E2: begin
          mem_addr_reg <= `IOD_LOC_EXT_NEW;
          mem_we_reg <= 1'b0;
          ret_reg <= iod_pkg::S_E3;
          state_reg <= iod_pkg::S_MEM;
        end
        iod_pkg::S_E3: begin
          sp_reg <= mem_rd_reg;
          mem_addr_reg <= `IOD_LOC_EXT_NEW + 16'h0002;
          ret_reg <= iod_pkg::S_E4;
          state_reg <= iod_pkg::S_MEM;
        end
        iod_pkg::S_E4: begin
          psw_reg <= {sp_reg, mem_rd_reg};
          pulse_reg[0] <= 1'b1;
          state_reg <= iod_pkg::S_IDLE;
        end
        iod_pkg::S_BLK: begin
          if (bcur_reg > bend_reg) begin
            blk_reg <= 1'b0; // RULE10
            state_reg <= iod_pkg::S_IDLE;
          end else if (blk_wr) begin
            mem_addr_reg <= bcur_reg;
            mem_we_reg <= 1'b0;
            ret_reg <= iod_pkg::S_BW;
            state_reg <= iod_pkg::S_MEM;
          end else begin
            state_reg <= iod_pkg::S_IO;
          end
        end
        iod_pkg::S_BW: begin
          dev_dout_reg <= mem_rd_reg[7:0];
          state_reg <= iod_pkg::S_IO;
        end
        iod_pkg::S_B1: begin
          if (cc_reg != 4'h0) begin
            blk_reg <= 1'b0; // RULE10
            state_reg <= iod_pkg::S_IDLE;
          end else if (blk_wr) begin
            state_reg <= iod_pkg::S_B2;
          end else begin
            mem_addr_reg <= bcur_reg;
            mem_we_reg <= 1'b1;
            mem_wdata_reg <= {8'h00, result_reg};
            ret_reg <= iod_pkg::S_B2;
            state_reg <= iod_pkg::S_MEM;
          end
        end
        iod_pkg::S_B2: begin
          bcur_reg <= bcur_reg + 16'h0001;
          state_reg <= iod_pkg::S_BLK;
        end
        default: begin
          state_reg <= iod_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  tmo_report_a: assert property ( // RULE2
    io_wait && tmo && !resp_s |=> cc_reg[`IOD_CC_TMO] && !io_wait)
    else $error("Time-out not reported.");
  priv_refuse_a: assert property ( // RULE3
    idle && cmd_pend_reg && psw_prot |=> idle && cc_reg[`IOD_CC_PRIV])
    else $error("Privileged command ran outside supervisor mode.");
  ext_path_a: assert property ( // RULE4
    idle && !cmd_pend_reg && irq_go && !imm_en |=> mem_req && mem_we
      && mem_addr == `IOD_LOC_EXT_OLD)
    else $error("External path did not save status.");
  imm_path_a: assert property ( // RULE5
    idle && !cmd_pend_reg && irq_go && imm_en |=> state_reg == iod_pkg::S_ACK
      && dev_req && dev_fn == `IOD_OP_ACK)
    else $error("Immediate path did not acknowledge.");
  table_index_a: assert property ( // RULE21
    state_reg == iod_pkg::S_ACK && resp_s && auto_reg |=> mem_req
      && mem_addr == $past(spt_addr) && dev_id_reg == $past(din_s))
    else $error("Table entry address wrong.");
  isb_entry_a: assert property ( // RULE17
    state_reg == iod_pkg::S_TBL && mem_rd_reg[0] |=> mem_req && !mem_we
      && mem_addr == $past(mem_rd_reg) - 16'h0001)
    else $error("Service block address not entry minus one.");
  blk_hold_a: assert property ( // RULE11
    blk_reg |-> !idle && !ext_int && !imm_int)
    else $error("Block move interrupted.");
  ovf_store_a: assert property ( // RULE23
    ovf_int |-> $past(mem_addr, 2) == `IOD_LOC_QOVF && $past(mem_we, 2))
    else $error("Overflow pointer not stored.");
  hold_busy_a: assert property ( // RULE12
    !idle && state_reg != iod_pkg::S_I3 && state_reg != iod_pkg::S_E4
      |-> cpu_hold ##1 $stable(psw_reg))
    else $error("Program not delayed or status word changed in service.");

  cov_ext_c: cover property (ext_int);
  cov_imm_c: cover property (imm_int);
  cov_term_c: cover property (term_int);
  cov_blk_c: cover property (blk_reg ##1 !blk_reg);

endmodule : iod_dispatch
`default_nettype wire

// file: verilog/iod_pkg.sv
// Types for the I/O interrupt dispatch block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package iod_pkg;
  typedef enum logic [4:0] {
    S_IDLE, S_MEM, S_IO, S_ACK, S_TBL, S_I1, S_I2, S_I3,
    S_F1, S_Q1, S_Q2, S_Q3, S_Q4, S_Q5, S_Q6, S_OVF,
    S_E1, S_E2, S_E3, S_E4, S_BLK, S_BW, S_B1, S_B2
  } iod_state_e;
endpackage : iod_pkg
`default_nettype wire
